// File: design/tmc_defs.svh
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// word offsets on the wishbone slave
`define TMC_OFS_RUN_CTRL 8'h00
`define TMC_OFS_MODE_CTRL 8'h04
`define TMC_OFS_CMP_A 8'h08
`define TMC_OFS_CMP_P 8'h0c
`define TMC_OFS_COUNT 8'h10

// run control register fields
`define TMC_RUN_BIT 3

// reset values
`define TMC_MODE_CTRL_RST 8'h00
`define TMC_CMP_A_RST 16'h0000
`define TMC_CMP_P_RST 8'h00

// input pin synchroniser depth
`define TMC_SYNC_STAGES 3

`endif

// File: design/tmc_pkg.sv
package tmc_pkg;

  typedef enum logic [1:0] {
    TMC_MODE_CMP = 2'b00,
    TMC_MODE_CAP = 2'b01,
    TMC_MODE_PWM = 2'b10,
    TMC_MODE_TMR = 2'b11
  } tmc_mode_t;

  // layout of the mode and output control register, bit 7 down to bit 0
  typedef struct packed {
    tmc_mode_t mode;
    logic [1:0] out_func;
    logic out_level;
    logic out_invert;
    logic period_duty_swap;
    logic clear_select;
  } tmc_ctl_t;

  typedef struct packed {
    logic [1:0] level;
    logic [1:0] oe_n;
  } tmc_pin_drive_t;

endpackage

// File: design/tmc_timer_ctrl.sv
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "tmc_defs.svh"
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
module tmc_timer_ctrl
  import tmc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PER_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // timer pins
  input wire logic [1:0] timer_pin_in,
  output logic [1:0] timer_pin_out,
  output logic [1:0] timer_pin_oe_n,
  // status
  output logic capture_event
);

  // -------------------------------------------------------------------
  // register bus
  // -------------------------------------------------------------------
  tmc_ctl_t ctl_r;
  logic timer_run_r;
  logic [CNT_W-1:0] cmp_a_r;
  logic [PER_W-1:0] cmp_p_r;
  logic [CNT_W-1:0] cnt_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic wr_en;
  logic cap_hit;

  // the answer comes one edge after the request; a write lands at the
  // edge that samples ack, so each access acts exactly once
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdat_r <= 32'h0000_0000;
    end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
      case (wb_adr_i)
        `TMC_OFS_RUN_CTRL: rdat_r <= 32'(timer_run_r) << `TMC_RUN_BIT;
        `TMC_OFS_MODE_CTRL: rdat_r <= {24'h00_0000, ctl_r};
        `TMC_OFS_CMP_A: rdat_r <= 32'(cmp_a_r);
        `TMC_OFS_CMP_P: rdat_r <= 32'(cmp_p_r);
        `TMC_OFS_COUNT: rdat_r <= 32'(cnt_r);
        default: rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= tmc_ctl_t'(`TMC_MODE_CTRL_RST);
    end else if (wr_en && wb_sel_i[0] && wb_adr_i == `TMC_OFS_MODE_CTRL) begin
      ctl_r <= tmc_ctl_t'(wb_dat_i[7:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_run_r <= 1'b0;
    end else if (wr_en && wb_sel_i[0] && wb_adr_i == `TMC_OFS_RUN_CTRL) begin
      timer_run_r <= wb_dat_i[`TMC_RUN_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_p_r <= `TMC_CMP_P_RST;
    end else if (wr_en && wb_sel_i[0] && wb_adr_i == `TMC_OFS_CMP_P) begin
      cmp_p_r <= wb_dat_i[PER_W-1:0];
    end
  end

  // a capture beats a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_a_r <= `TMC_CMP_A_RST;
    end else if (cap_hit) begin
      cmp_a_r <= cnt_r;
    end else if (wr_en && wb_adr_i == `TMC_OFS_CMP_A) begin
      if (wb_sel_i[0]) begin
        cmp_a_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        cmp_a_r[CNT_W-1:8] <= wb_dat_i[CNT_W-1:8];
      end
    end
  end

  // -------------------------------------------------------------------
  // counter and comparators
  // -------------------------------------------------------------------
  logic run_d_r;
  logic run_rise;
  logic [CNT_W-1:0] p_last;
  logic [CNT_W-1:0] per_last;
  logic [CNT_W:0] duty;
  logic a_match;
  logic p_end;
  logic cnt_clr;
  logic pwm_act;

  assign run_rise = timer_run_r & ~run_d_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_d_r <= 1'b0;
    end else begin
      run_d_r <= timer_run_r;
    end
  end

  // period register sets only the top bits of the full-width limit; zero wraps at full
  assign p_last = {cmp_p_r, 8'h00} - 16'h0001;
  assign a_match = (cnt_r == cmp_a_r);
  assign p_end = (cnt_r == p_last);

  always_comb begin
    if (ctl_r.period_duty_swap) begin
      per_last = cmp_a_r - 16'h0001;
      duty = (cmp_p_r == 8'h00) ? 17'h1_0000 : {1'b0, cmp_p_r, 8'h00};
    end else begin
      per_last = p_last;
      duty = {1'b0, cmp_a_r};
    end
  end

  // duty at or beyond the period gives a constantly active wave
  assign pwm_act = ({1'b0, cnt_r} < duty);

  always_comb begin
    if (ctl_r.mode == TMC_MODE_PWM) begin
      cnt_clr = (cnt_r == per_last);
    end else if (ctl_r.clear_select) begin
      cnt_clr = a_match;
    end else begin
      cnt_clr = p_end;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (run_rise) begin
      cnt_r <= '0;
    end else if (timer_run_r) begin
      cnt_r <= cnt_clr ? '0 : cnt_r + 16'h0001;
    end
  end

  // -------------------------------------------------------------------
  // capture input
  // -------------------------------------------------------------------
  logic [`TMC_SYNC_STAGES-1:0] sync_r [2];
  logic [1:0] pin_lvl_r;
  logic [1:0] rise;
  logic [1:0] fall;

  for (genvar g = 0; g < 2; g++) begin : g_pin
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        sync_r[g] <= '0;
        pin_lvl_r[g] <= 1'b0;
      end else begin
        sync_r[g] <= {sync_r[g][1:0], timer_pin_in[g]};
        // a change counts only once the last two stages agree
        if (sync_r[g][1] == sync_r[g][2]) begin
          pin_lvl_r[g] <= sync_r[g][2];
        end
      end
    end
    assign rise[g] = (sync_r[g][1] == sync_r[g][2]) &
                     sync_r[g][2] & ~pin_lvl_r[g];
    assign fall[g] = (sync_r[g][1] == sync_r[g][2]) &
                     ~sync_r[g][2] & pin_lvl_r[g];
  end

  always_comb begin
    cap_hit = 1'b0;
    if (ctl_r.mode == TMC_MODE_CAP && timer_run_r) begin
      case (ctl_r.out_func)
        2'b00: begin
          cap_hit = |rise;
        end
        2'b01: begin
          cap_hit = |fall;
        end
        2'b10: begin
          cap_hit = |(rise | fall);
        end
        default: begin
          cap_hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      capture_event <= 1'b0;
    end else begin
      capture_event <= cap_hit;
    end
  end

  // -------------------------------------------------------------------
  // output waveform
  // -------------------------------------------------------------------
  logic cmp_out_r;
  logic pulse_live_r;
  logic wave;
  tmc_pin_drive_t drv_r;

  // initial level is reloaded on each run start, so a stopped timer
  // keeps whatever level the last match left behind
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_out_r <= 1'b0;
    end else if (ctl_r.mode != TMC_MODE_CMP) begin
      cmp_out_r <= ctl_r.out_level;
    end else if (run_rise) begin
      cmp_out_r <= ctl_r.out_level;
    end else if (timer_run_r && a_match) begin
      case (ctl_r.out_func)
        2'b01: begin
          cmp_out_r <= 1'b0;
        end
        2'b10: begin
          cmp_out_r <= 1'b1;
        end
        2'b11: begin
          cmp_out_r <= ~cmp_out_r;
        end
        default: begin
          cmp_out_r <= cmp_out_r;
        end
      endcase
    end
  end

  // single pulse lasts the first period after a run start
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_live_r <= 1'b0;
    end else if (run_rise) begin
      pulse_live_r <= 1'b1;
    end else if (!timer_run_r || cnt_clr) begin
      pulse_live_r <= 1'b0;
    end
  end

  always_comb begin
    case (ctl_r.mode)
      TMC_MODE_CMP: begin
        wave = cmp_out_r;
      end
      TMC_MODE_PWM: begin
        case (ctl_r.out_func)
          2'b00: begin
            wave = ~ctl_r.out_level;
          end
          2'b01: begin
            wave = ctl_r.out_level;
          end
          2'b10: begin
            wave = pwm_act ? ctl_r.out_level : ~ctl_r.out_level;
          end
          default: begin
            wave = (pulse_live_r & pwm_act) ? ctl_r.out_level
                                            : ~ctl_r.out_level;
          end
        endcase
      end
      default: begin
        wave = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      drv_r <= '{level: 2'b00, oe_n: 2'b11};
    end else if (ctl_r.mode inside {TMC_MODE_TMR, TMC_MODE_CAP}) begin
      drv_r <= '{level: 2'b00, oe_n: 2'b11};
    end else begin
      drv_r <= '{level: {2{wave ^ ctl_r.out_invert}}, oe_n: 2'b00};
    end
  end

  assign timer_pin_out = drv_r.level;
  assign timer_pin_oe_n = drv_r.oe_n;

endmodule // tmc_timer_ctrl

// File: sim/tb_timer_mode_output_control.sv
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tb_timer_mode_output_control;
  localparam logic [7:0] RUN = `TMC_OFS_RUN_CTRL;
  localparam logic [7:0] MOD = `TMC_OFS_MODE_CTRL;
  localparam logic [7:0] CNT = `TMC_OFS_COUNT;
  logic ref_clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ext = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, q, c, seed = 32'h0000a086;
  logic ack, cap;
  logic [1:0] pin_in, pin_out, oe_n;
  int fails = 0, total_checks = 0, ncap = 0, ctl_m = 0, k, n0, per, duty, e;
  initial forever #20 ref_clk = ~ref_clk;
  tmc_timer_ctrl uut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timer_pin_in(pin_in), .timer_pin_out(pin_out),
    .timer_pin_oe_n(oe_n), .capture_event(cap));
  tmc_pin_model u_pins (.pin_out(pin_out), .oe_n(oe_n), .ext_lvl(ext),
    .pin_in(pin_in));
  always @(posedge ref_clk) if (cap === 1'b1) ncap <= ncap + 1;
  // ------------
  // bench tasks
  // ------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("wrong value at %0t: %h not %h", $time, s, x);
    end
  endtask
  // one classic cycle; the extra edge keeps cyc low between requests
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    if (ack !== 1'b1) begin
      fails++;
      finish_test();
    end
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1, a, d);
    if (a == MOD) ctl_m = d & 32'hff;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(0, a, 0);
    chk(q, x);
  endtask
  task automatic win(input int n, input logic a);
    k = 0;
    repeat (n) begin
      @(posedge ref_clk);
      if (pin_out[0] === a) k++;
    end
  endtask
  // ---------
  // sequence
  // ---------
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1;
    @(posedge ref_clk);
    rd(MOD, 0);
    for (int i = 0; i < 4; i++) begin
      wr(MOD, rnd());
      rd(MOD, ctl_m);
    end
    wr(8'h20, rnd());
    rd(8'h20, 0);
    rd(MOD, ctl_m);
    wr(`TMC_OFS_CMP_A, 5);
    for (int i = 0; i < 16; i++) begin
      wr(RUN, 0);
      wr(MOD, i << 2);
      wr(RUN, 8);
      // the reload lands one edge after the run start, the pin one later
      repeat (2) @(posedge ref_clk);
      chk(pin_out, {2{i[1] ^ i[0]}});
      repeat (20) @(posedge ref_clk);
      e = i[3:2] == 0 ? i[1] : i[3:2] == 1 ? 0 : i[3:2] == 2 ? 1 : !i[1];
      chk(pin_out, {2{e[0] ^ i[0]}});
      wr(RUN, 0);
      wb(0, CNT, 0);
      c = q;
      // cleared on the run start, then one count per clock until stopped
      chk(c, 24);
      repeat (4) @(posedge ref_clk);
      rd(CNT, c);
    end
    // pwm windows span two whole periods so the phase does not matter for the repeating waves; the single pulse gets a margin of 16
    for (int j = 0; j < 8; j++) begin
      c = rnd();
      per = j[0] ? 300 : 256;
      duty = j[0] ? 256 : 64;
      wr(RUN, 0);
      wr(`TMC_OFS_CMP_A, j[0] ? 300 : 64);
      wr(`TMC_OFS_CMP_P, 1);
      wr(MOD, {24'h0, 2'b10, j[2:1], c[1:0], j[0], 1'b0});
      wr(RUN, 8);
      repeat (8) @(posedge ref_clk);
      win(2 * per, c[1] ^ c[0]);
      if (j[2:1] == 3) chk(k > duty - 16 && k <= duty, 1);
      else chk(k, j[2:1] == 0 ? 0 : j[2:1] == 1 ? 2 * per : 2 * duty);
    end
    for (int f = 0; f < 4; f++) begin
      wr(RUN, 0);
      wr(MOD, 8'h40 | f << 4);
      wr(RUN, 8);
      repeat (8) @(posedge ref_clk);
      n0 = ncap;
      ext <= 1;
      repeat (10) @(posedge ref_clk);
      chk(ncap - n0, f == 0 || f == 2);
      n0 = ncap;
      ext <= 0;
      repeat (10) @(posedge ref_clk);
      chk(ncap - n0, f == 1 || f == 2);
    end
    wr(RUN, 0);
    wr(MOD, 8'h9c);
    @(posedge ref_clk);
    chk({oe_n, pin_out}, 4'h0);
    wr(MOD, 8'hcc);
    wr(RUN, 8);
    repeat (3) @(posedge ref_clk);
    chk({oe_n, pin_out}, 4'hc);
    finish_test();
  end
endmodule // tb_timer_mode_output_control

// File: sim/tmc_pin_model.sv
`timescale 1ns/1ps
module tmc_pin_model (
  // device side
  input wire logic [1:0] pin_out,
  input wire logic [1:0] oe_n,
  // outside level
  input wire logic ext_lvl,
  // level at the device inputs
  output logic [1:0] pin_in
);
  // -----------
  // wire level
  // -----------
  // outside circuit drives only a released pin; a driven pin reads back
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_in[i] = oe_n[i] ? ext_lvl : pin_out[i];
    end
  end
endmodule // tmc_pin_model

// File: sim/tmc_timer_ctrl_asserts.sv
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_timer_ctrl_asserts
  import tmc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PER_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic [1:0] timer_pin_in,
  input wire logic [1:0] timer_pin_out,
  input wire logic [1:0] timer_pin_oe_n,
  input wire logic capture_event
);
  // -----------
  // mode shadow
  // -----------
  // rebuilt from bus writes, since the mode is not visible at the ports
  logic [1:0] mode_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= 2'b00;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `TMC_OFS_MODE_CTRL) begin
      mode_r <= wb_dat_i[7:6];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_data_hold: assert property (
    !(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved");
  a_pins_equal: assert property (
    timer_pin_out[0] == timer_pin_out[1] &&
    timer_pin_oe_n[0] == timer_pin_oe_n[1]) else $error("pins differ");
  a_undriven_mode: assert property (
    mode_r[0] |=> timer_pin_oe_n == 2'b11) else $error("pin driven");
  a_cmp_drives: assert property (
    (mode_r == 2'b00) [*3] |-> timer_pin_oe_n == 2'b00)
    else $error("compare pin idle");
  a_cap_single: assert property (
    capture_event |=> !capture_event) else $error("capture too long");
  a_cap_mode: assert property (
    capture_event |-> mode_r == 2'b01) else $error("capture out of mode");
endmodule // tmc_timer_ctrl_asserts

bind tmc_timer_ctrl tmc_timer_ctrl_asserts #(.CNT_W(CNT_W), .PER_W(PER_W))
  u_chk (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .timer_pin_in(timer_pin_in),
  .timer_pin_out(timer_pin_out), .timer_pin_oe_n(timer_pin_oe_n),
  .capture_event(capture_event));
